// file: hdl/lkd_pkg.sv
// package: constants, field layout and types of the lock detect and dither control block
// assumes a single 200 MHz clock and a classic wishbone register bus
package lkd_pkg;

    localparam int CLK_PERIOD_PS = 5000;

    // register byte addresses
    localparam logic [3:0] LKD_ADDR_CTRL     = 4'h0;
    localparam logic [3:0] LKD_ADDR_STATUS   = 4'h4;
    localparam logic [3:0] LKD_ADDR_IRQ_STAT = 4'h8;
    localparam logic [3:0] LKD_ADDR_IRQ_MASK = 4'hC;

    // control field positions
    localparam int CTRL_DITHER_STRENGTH_SEL_LSB  = 0;
    localparam int CTRL_HIZ_BIT   = 2;
    localparam int CTRL_WIN_LSB   = 3;
    localparam int CTRL_PIN_LSB   = 6;
    localparam int CTRL_ORDER_LSB = 10;
    localparam int CTRL_WIDTH     = 13;

    // irq bit positions
    localparam int IRQ_LOCK_GAIN = 0;
    localparam int IRQ_LOCK_LOSS = 1;
    localparam int IRQ_REF_LOSS  = 2;
    localparam int IRQ_WIDTH     = 3;

    // reset values
    localparam logic [1:0] DITHER_STRENGTH_SEL_RST  = 2'h3;
    localparam logic       HIZ_RST   = 1'b0;
    localparam logic [2:0] WIN_RST   = 3'h0;
    localparam logic [3:0] PIN_RST   = 4'h0;
    localparam logic [2:0] ORDER_RST = 3'h0;

    // dither strength codes
    localparam logic [1:0] DITHER_STRENGTH_SEL_WEAK   = 2'h0;
    localparam logic [1:0] DITHER_STRENGTH_SEL_MEDIUM = 2'h1;
    localparam logic [1:0] DITHER_STRENGTH_SEL_STRONG = 2'h2;
    localparam logic [1:0] DITHER_STRENGTH_SEL_OFF    = 2'h3;

    // test pin function codes
    localparam logic [3:0] PIN_HIZ      = 4'h0;
    localparam logic [3:0] PIN_HIGH     = 4'h1;
    localparam logic [3:0] PIN_LOW      = 4'h2;
    localparam logic [3:0] PIN_LOCK_PP  = 4'h3;
    localparam logic [3:0] PIN_LOCK_INV = 4'h4;
    localparam logic [3:0] PIN_LOCK_OD  = 4'h5;

    localparam logic [2:0] WIN_CODE_MAX   = 3'h5;
    localparam logic [2:0] ORDER_CODE_MAX = 3'h4;

    // lock window sizes in ps, codes 0..5
    localparam int WIN0_PS = 3500;
    localparam int WIN1_PS = 5500;
    localparam int WIN2_PS = 7500;
    localparam int WIN3_PS = 9500;
    localparam int WIN4_PS = 11500;
    localparam int WIN5_PS = 13500;

    localparam logic [2:0] LOCK_COUNT  = 3'h5;
    localparam int         CNT_W       = 8;
    localparam int         REF_LOSS_NS = 1000;
    localparam int         REF_LOSS_CYC = REF_LOSS_NS * 1000 / CLK_PERIOD_PS;

    typedef struct packed {
        logic [2:0] order;
        logic [3:0] pin_sel;
        logic [2:0] win;
        logic       hiz;
        logic [1:0] dither_strength_sel;
    } lkd_ctrl_t;

    typedef struct packed {
        logic       valid;
        logic       in_window;
    } lkd_cmp_t;

    // a longest time rounds down, never below one cycle
    function automatic logic [CNT_W-1:0] win_cycles(input logic [2:0] code);
        int ps;
        int cyc;
        case (code)
            3'h0:    ps = WIN0_PS;
            3'h1:    ps = WIN1_PS;
            3'h2:    ps = WIN2_PS;
            3'h3:    ps = WIN3_PS;
            3'h4:    ps = WIN4_PS;
            default: ps = WIN5_PS;
        endcase
        cyc = ps / CLK_PERIOD_PS;
        if (cyc < 1)
        begin
            cyc = 1;
        end
        return cyc[CNT_W-1:0];
    endfunction : win_cycles

endpackage : lkd_pkg

// file: hdl/lkd_sync.sv
// two flip-flop synchroniser for a group of asynchronous levels
// assumes the inputs change slowly relative to clk_i
`timescale 1ns/1ps
`default_nettype none
module lkd_sync
    import lkd_pkg::*;
#(
    parameter int W = 2
)(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] async_i,
    output var  logic [W-1:0] sync_o
);
    logic [W-1:0] meta_reg;

    // first stage feeds only the second
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_reg <= '0;
            sync_o   <= '0;
        end
        else
        begin
            meta_reg <= async_i;
            sync_o   <= meta_reg;
        end
    end
endmodule : lkd_sync
`default_nettype wire

// file: hdl/lkd_phase_cmp.sv
// measures divider edge offset per comparison, checks it against the window
// assumes synchronised divider outputs on clk_i
`timescale 1ns/1ps
`default_nettype none
module lkd_phase_cmp
    import lkd_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             ref_i,
    input  wire logic             fb_i,
    input  wire logic [CNT_W-1:0] win_cyc_i,
    output var  lkd_cmp_t         cmp_o
);
    typedef enum {CMP_IDLE, CMP_WAIT_FB, CMP_WAIT_REF} lkd_cmp_state_t;

    lkd_cmp_state_t   state_reg;
    logic             ref_d_reg;
    logic             fb_d_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic             ref_rise;
    logic             fb_rise;
    logic             cnt_max;

    assign ref_rise = ref_i & ~ref_d_reg;
    assign fb_rise  = fb_i & ~fb_d_reg;
    assign cnt_max  = (cnt_reg == '1);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ref_d_reg <= 1'b0;
            fb_d_reg  <= 1'b0;
        end
        else
        begin
            ref_d_reg <= ref_i;
            fb_d_reg  <= fb_i;
        end
    end

    // window read at the closing edge, so a new code also applies to a compare already in progress
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= CMP_IDLE;
            cnt_reg   <= '0;
            cmp_o     <= '0;
        end
        else
        begin
            cmp_o <= '0;
            case (state_reg)
                CMP_IDLE:
                begin
                    cnt_reg <= 8'h01;
                    if (ref_rise && fb_rise)
                    begin
                        cmp_o <= '{valid: 1'b1, in_window: 1'b1};
                    end
                    else if (ref_rise)
                    begin
                        state_reg <= CMP_WAIT_FB;
                    end
                    else if (fb_rise)
                    begin
                        state_reg <= CMP_WAIT_REF;
                    end
                end
                CMP_WAIT_FB, CMP_WAIT_REF:
                begin
                    if ((state_reg == CMP_WAIT_FB) ? fb_rise : ref_rise)
                    begin
                        cmp_o     <= '{valid: 1'b1, in_window: (cnt_reg < win_cyc_i)};
                        state_reg <= CMP_IDLE;
                    end
                    else if (((state_reg == CMP_WAIT_FB) ? ref_rise : fb_rise) || cnt_max)
                    begin
                        // a repeated edge or a stall is a miss; restart from idle
                        cmp_o     <= '{valid: 1'b1, in_window: 1'b0};
                        state_reg <= CMP_IDLE;
                    end
                    else
                    begin
                        cnt_reg <= cnt_reg + 8'h01;
                    end
                end
                default: state_reg <= CMP_IDLE;
            endcase
        end
    end
endmodule : lkd_phase_cmp
`default_nettype wire

// file: hdl/lkd_top.sv
// digital lock detect, dither strength and charge pump hi-z control
// assumes divider outputs arrive asynchronously; registers on classic wishbone
// How it works
// - dither field picks weak, medium, strong, off
// - pump hi-z bit floats the charge pump
// - lock after five consecutive in-window comparisons
// - test pin goes high when locked
// - one out-of-window comparison drops lock
// - lost reference forces the unlocked state
// - window codes 0..5, 6 and 7 reserved
// - pin selector: 3 true, 4 inverse, 5 open drain
// - order codes 0..4 valid, 5..7 illegal
//
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module lkd_top
    import lkd_pkg::*;
#(
    parameter int REF_LOSS_CYCLES = REF_LOSS_CYC
)(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output var  logic [31:0] wb_dat_o,
    output var  logic        wb_ack_o,
    input  wire logic        ref_div_i,
    input  wire logic        fb_div_i,
    output var  logic [1:0]  dither_strength_sel_o,
    output var  logic        dither_enable_o,
    output var  logic [2:0]  modulator_order_o,
    output var  logic        pump_hiz_enable_o,
    output var  logic        test_lock_pin_o,
    output var  logic        test_lock_pin_oe_o,
    output var  logic        irq_o
);
    lkd_ctrl_t               ctrl_reg;
    logic [IRQ_WIDTH-1:0]    irq_stat_reg;
    logic [IRQ_WIDTH-1:0]    irq_mask_reg;
    logic [1:0]              div_sync;
    lkd_cmp_t                cmp;
    logic [CNT_W-1:0]        win_cyc;
    logic [2:0]              count_reg;
    logic                    ref_lost_reg;
    logic [31:0]             loss_cnt_reg;
    logic                    ref_d_reg;
    logic                    ref_rise;
    logic                    wr_stb;
    logic [IRQ_WIDTH-1:0]    irq_event;
    lkd_ctrl_t               wr_ctrl;

    typedef enum {LK_UNLOCKED, LK_LOCKED} lkd_lock_state_t;
    lkd_lock_state_t         lock_reg;

    lkd_sync #(.W(2)) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i ({ref_div_i, fb_div_i}),
        .sync_o  (div_sync)
    );

    assign win_cyc = win_cycles(ctrl_reg.win);

    lkd_phase_cmp u_cmp (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .ref_i     (div_sync[1]),
        .fb_i      (div_sync[0]),
        .win_cyc_i (win_cyc),
        .cmp_o     (cmp)
    );

    // bus: ack one cycle after request, write at the edge where ack is seen
    assign wr_stb  = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
    assign wr_ctrl = lkd_ctrl_t'(wb_dat_i[CTRL_WIDTH-1:0]);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            wb_dat_o <= 32'h00000000;
            if (wb_cyc_i && wb_stb_i && !wb_ack_o)
            begin
                case (wb_adr_i)
                    LKD_ADDR_CTRL:     wb_dat_o <= {19'h00000, ctrl_reg};
                    LKD_ADDR_STATUS:   wb_dat_o <= {27'h0, ref_lost_reg, count_reg,
                                                    (lock_reg == LK_LOCKED)};
                    LKD_ADDR_IRQ_STAT: wb_dat_o <= {29'h00000000, irq_stat_reg};
                    LKD_ADDR_IRQ_MASK: wb_dat_o <= {29'h00000000, irq_mask_reg};
                    default:           wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

    // reserved window and illegal order codes are dropped, keeping the old value
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_reg <= '{order: ORDER_RST, pin_sel: PIN_RST, win: WIN_RST,
                          hiz: HIZ_RST, dither_strength_sel: DITHER_STRENGTH_SEL_RST};
        end
        else if (wr_stb && wb_adr_i == LKD_ADDR_CTRL)
        begin
            if (wb_sel_i[0])
            begin
                ctrl_reg.dither_strength_sel <= wr_ctrl.dither_strength_sel;
                ctrl_reg.hiz  <= wr_ctrl.hiz;
                if (wr_ctrl.win <= WIN_CODE_MAX)
                begin
                    ctrl_reg.win <= wr_ctrl.win;
                end
                ctrl_reg.pin_sel[1:0] <= wr_ctrl.pin_sel[1:0];
            end
            if (wb_sel_i[1])
            begin
                ctrl_reg.pin_sel[3:2] <= wr_ctrl.pin_sel[3:2];
                if (wr_ctrl.order <= ORDER_CODE_MAX)
                begin
                    ctrl_reg.order <= wr_ctrl.order;
                end
            end
        end
    end

    // reference loss watchdog, counts clocks since the last reference edge
    assign ref_rise = div_sync[1] & ~ref_d_reg;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ref_d_reg    <= 1'b0;
            loss_cnt_reg <= 32'h00000000;
            ref_lost_reg <= 1'b0;
        end
        else
        begin
            ref_d_reg <= div_sync[1];
            if (ref_rise)
            begin
                loss_cnt_reg <= 32'h00000000;
                ref_lost_reg <= 1'b0;
            end
            else if (loss_cnt_reg >= 32'(REF_LOSS_CYCLES))
            begin
                ref_lost_reg <= 1'b1;
            end
            else
            begin
                loss_cnt_reg <= loss_cnt_reg + 32'h00000001;
            end
        end
    end

    // lock state with shared acquire and release window
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            lock_reg  <= LK_UNLOCKED;
            count_reg <= 3'h0;
        end
        else if (ref_lost_reg)
        begin
            lock_reg  <= LK_UNLOCKED;
            count_reg <= 3'h0;
        end
        else if (cmp.valid)
        begin
            case (lock_reg)
                LK_UNLOCKED:
                begin
                    if (!cmp.in_window)
                    begin
                        count_reg <= 3'h0;
                    end
                    else if (count_reg == LOCK_COUNT - 3'h1)
                    begin
                        lock_reg  <= LK_LOCKED;
                        count_reg <= 3'h0;
                    end
                    else
                    begin
                        count_reg <= count_reg + 3'h1;
                    end
                end
                LK_LOCKED:
                begin
                    if (!cmp.in_window)
                    begin
                        lock_reg <= LK_UNLOCKED;
                    end
                end
                default: lock_reg <= LK_UNLOCKED;
            endcase
        end
    end

    // sticky events; a new event beats a same-cycle clear
    assign irq_event[IRQ_LOCK_GAIN] = (lock_reg == LK_UNLOCKED) && !ref_lost_reg && cmp.valid
                                      && cmp.in_window && count_reg == LOCK_COUNT - 3'h1;
    assign irq_event[IRQ_LOCK_LOSS] = (lock_reg == LK_LOCKED) && (ref_lost_reg
                                      || (cmp.valid && !cmp.in_window));
    assign irq_event[IRQ_REF_LOSS]  = !ref_lost_reg && !ref_rise
                                      && loss_cnt_reg >= 32'(REF_LOSS_CYCLES);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
        end
        else
        begin
            if (wr_stb && wb_adr_i == LKD_ADDR_IRQ_STAT && wb_sel_i[0])
            begin
                irq_stat_reg <= (irq_stat_reg & ~wb_dat_i[IRQ_WIDTH-1:0]) | irq_event;
            end
            else
            begin
                irq_stat_reg <= irq_stat_reg | irq_event;
            end
            if (wr_stb && wb_adr_i == LKD_ADDR_IRQ_MASK && wb_sel_i[0])
            begin
                irq_mask_reg <= wb_dat_i[IRQ_WIDTH-1:0];
            end
        end
    end

    // outputs, all registered
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dither_strength_sel_o <= DITHER_STRENGTH_SEL_RST;
            dither_enable_o       <= 1'b0;
            modulator_order_o     <= ORDER_RST;
            pump_hiz_enable_o     <= HIZ_RST;
            irq_o                 <= 1'b0;
        end
        else
        begin
            dither_strength_sel_o <= ctrl_reg.dither_strength_sel;
            dither_enable_o       <= (ctrl_reg.dither_strength_sel != DITHER_STRENGTH_SEL_OFF);
            modulator_order_o     <= ctrl_reg.order;
            pump_hiz_enable_o     <= ctrl_reg.hiz;
            irq_o                 <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // analog and diagnostic selections live elsewhere; pin floats for them
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            test_lock_pin_o    <= 1'b0;
            test_lock_pin_oe_o <= 1'b0;
        end
        else
        begin
            case (ctrl_reg.pin_sel)
                PIN_HIGH:
                begin
                    test_lock_pin_o    <= 1'b1;
                    test_lock_pin_oe_o <= 1'b1;
                end
                PIN_LOW:
                begin
                    test_lock_pin_o    <= 1'b0;
                    test_lock_pin_oe_o <= 1'b1;
                end
                PIN_LOCK_PP:
                begin
                    test_lock_pin_o    <= (lock_reg == LK_LOCKED);
                    test_lock_pin_oe_o <= 1'b1;
                end
                PIN_LOCK_INV:
                begin
                    test_lock_pin_o    <= (lock_reg != LK_LOCKED);
                    test_lock_pin_oe_o <= 1'b1;
                end
                PIN_LOCK_OD:
                begin
                    test_lock_pin_o    <= 1'b0;
                    test_lock_pin_oe_o <= (lock_reg != LK_LOCKED);
                end
                default:
                begin
                    test_lock_pin_o    <= 1'b0;
                    test_lock_pin_oe_o <= 1'b0;
                end
            endcase
        end
    end

    a_lock_after_five: assert property (@(posedge clk_i) disable iff (rst_i)
        (lock_reg == LK_UNLOCKED ##1 lock_reg == LK_LOCKED)
        |-> $past(count_reg) == LOCK_COUNT - 3'h1 && $past(cmp.valid && cmp.in_window))
        else $error("lock declared without five good comparisons");
    a_drop_on_miss: assert property (@(posedge clk_i) disable iff (rst_i)
        (lock_reg == LK_LOCKED && cmp.valid && !cmp.in_window) |=> lock_reg == LK_UNLOCKED)
        else $error("lock held after out-of-window comparison");
    a_hold_lock: assert property (@(posedge clk_i) disable iff (rst_i)
        (lock_reg == LK_LOCKED && !ref_lost_reg && !(cmp.valid && !cmp.in_window))
        |=> lock_reg == LK_LOCKED)
        else $error("lock dropped without cause");
    a_ref_loss_unlock: assert property (@(posedge clk_i) disable iff (rst_i)
        ref_lost_reg |=> lock_reg == LK_UNLOCKED && count_reg == 3'h0)
        else $error("lock kept with reference gone");
    a_count_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (lock_reg == LK_UNLOCKED && cmp.valid && !cmp.in_window) |=> count_reg == 3'h0)
        else $error("count not cleared on miss");
    a_pin_true_lock: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctrl_reg.pin_sel == PIN_LOCK_PP && $stable(ctrl_reg.pin_sel) && lock_reg == LK_LOCKED)
        ##1 $stable(lock_reg) |-> test_lock_pin_o && test_lock_pin_oe_o)
        else $error("test pin not high while locked");
    a_pin_open_drain: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_reg.pin_sel == PIN_LOCK_OD |=> !test_lock_pin_o)
        else $error("open drain mode drove the pin high");
    a_pump_hiz: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 pump_hiz_enable_o == $past(ctrl_reg.hiz))
        else $error("pump hi-z does not follow its bit");
    a_dither_off: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_reg.dither_strength_sel == DITHER_STRENGTH_SEL_OFF |=> !dither_enable_o)
        else $error("dither enabled with strength off");
    a_window_legal: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_reg.win <= WIN_CODE_MAX && ctrl_reg.order <= ORDER_CODE_MAX)
        else $error("reserved window or illegal order stored");
endmodule : lkd_top
`default_nettype wire

// file: tb/tb.sv
// testbench: model comparison of lkd_top registers, outputs and lock detect
// assumes 200 MHz clk_i, synchronous active-high reset, classic wishbone
`timescale 1ns/1ps
`default_nettype none
module tb;
    import lkd_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    logic        ref_d = 1'b0;
    logic        fb_d = 1'b0;
    logic [1:0]  dither_strength_sel;
    logic        den;
    logic [2:0]  ord;
    logic        hiz;
    logic        pin;
    logic        pin_oe;
    logic        irq;
    logic [31:0] q;
    logic [31:0] d;
    logic [12:0] m;
    logic [3:0]  wsel = 4'hF;
    int          fails = 0;
    int          compares = 0;
    int          seed = 32'ha993;

    always #2.5 clk_i = ~clk_i;

    lkd_top #(.REF_LOSS_CYCLES(64)) lkd_top_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .ref_div_i(ref_d), .fb_div_i(fb_d), .dither_strength_sel_o(dither_strength_sel),
        .dither_enable_o(den), .modulator_order_o(ord), .pump_hiz_enable_o(hiz),
        .test_lock_pin_o(pin), .test_lock_pin_oe_o(pin_oe), .irq_o(irq)
    );

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task print_verdict;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict

    // one classic cycle; waits for ack without assuming its delay
    task wb(input logic w, input logic [3:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        sel <= wsel;
        dat <= wd;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        if (n >= 50)
            fails++;
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    // one comparison period of 39 clocks, feedback edge late by off clocks
    task period(input int off);
        @(posedge clk_i);
        ref_d <= 1'b1;
        repeat (off) @(posedge clk_i);
        fb_d <= 1'b1;
        repeat (20 - off) @(posedge clk_i);
        ref_d <= 1'b0;
        fb_d  <= 1'b0;
        repeat (18) @(posedge clk_i);
    endtask : period

    // {oe, driven level}; a floating pin reads as 00
    function automatic logic [1:0] pin_exp(input logic [3:0] p, input logic lk);
        case (p)
            4'h1:    return 2'b11;
            4'h2:    return 2'b10;
            4'h3:    return {1'b1, lk};
            4'h4:    return {1'b1, ~lk};
            4'h5:    return {~lk, 1'b0};
            default: return 2'b00;
        endcase
    endfunction : pin_exp

    task pin_chk(input logic [1:0] e);
        repeat (2) @(posedge clk_i);
        chk({30'h0, pin_oe, pin_oe & pin}, {30'h0, e});
    endtask : pin_chk

    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        m = 13'h003;
        wb(1'b0, LKD_ADDR_CTRL, 32'h0);
        chk(q, 32'h3);
        chk({24'h0, dither_strength_sel, den, hiz, ord, pin_oe}, 32'hC0);
        wb(1'b0, 4'h2, 32'h0);
        chk(q, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 16; i++)
        begin
            d = {19'h0, 3'(~i), 4'(i), 3'(i), 1'($random(seed)), 2'(i >> 2)};
            if (d[12:10] <= 3'h4)
                m[12:10] = d[12:10];
            // no dither in integer or first order mode
            if (m[12:10] < 3'h2)
                d[1:0] = 2'h3;
            m[2:0] = d[2:0];
            m[9:6] = d[9:6];
            if (d[5:3] <= 3'h5)
                m[5:3] = d[5:3];
            wb(1'b1, LKD_ADDR_CTRL, d);
            pin_chk(pin_exp(m[9:6], 1'b0));
            chk({25'h0, dither_strength_sel, den, hiz, ord}, {25'h0, m[1:0], m[1:0] != 2'h3, m[2], m[12:10]});
            wb(1'b0, LKD_ADDR_CTRL, 32'h0);
            chk(q, {19'h0, m});
        end
        // lane 1 only: pin_sel[3:2] and order move, lane 0 fields stay
        wsel = 4'h2;
        wb(1'b1, LKD_ADDR_CTRL, 32'h00000BFF);
        wsel = 4'hF;
        m[9:8] = 2'b11;
        m[12:10] = 3'h2;
        wb(1'b0, LKD_ADDR_CTRL, 32'h0);
        chk(q, {19'h0, m});
        $display("test fields done");
        wb(1'b1, LKD_ADDR_IRQ_MASK, 32'h1);
        wb(1'b1, LKD_ADDR_CTRL, 32'h0C3);
        repeat (3) period(0);
        period(10);
        repeat (4) period(0);
        wb(1'b0, LKD_ADDR_STATUS, 32'h0);
        chk(q & 32'h1, 32'h0);
        chk(q & 32'hE, 32'h8);
        chk({31'h0, irq}, 32'h0);
        period(0);
        wb(1'b0, LKD_ADDR_STATUS, 32'h0);
        chk(q & 32'h1, 32'h1);
        pin_chk(2'b11);
        chk({31'h0, irq}, 32'h1);
        wb(1'b0, LKD_ADDR_IRQ_STAT, 32'h0);
        chk(q & 32'h1, 32'h1);
        wb(1'b1, LKD_ADDR_IRQ_STAT, 32'h1);
        repeat (3) @(posedge clk_i);
        chk({31'h0, irq}, 32'h0);
        $display("test lock done");
        wb(1'b1, LKD_ADDR_CTRL, 32'h103);
        pin_chk(2'b10);
        period(10);
        wb(1'b0, LKD_ADDR_STATUS, 32'h0);
        chk(q & 32'h1, 32'h0);
        pin_chk(2'b11);
        wb(1'b0, LKD_ADDR_IRQ_STAT, 32'h0);
        chk(q & 32'h2, 32'h2);
        $display("test unlock done");
        // a one-clock offset only fits the wider two-clock window
        wb(1'b1, LKD_ADDR_CTRL, 32'h16B);
        repeat (5) period(1);
        wb(1'b0, LKD_ADDR_STATUS, 32'h0);
        chk(q & 32'h1, 32'h1);
        pin_chk(2'b00);
        repeat (120) @(posedge clk_i);
        wb(1'b0, LKD_ADDR_STATUS, 32'h0);
        chk(q & 32'h11, 32'h10);
        pin_chk(2'b10);
        $display("test reference loss done");
        print_verdict();
    end

    // whole run is near 900 clocks
    initial
    begin
        repeat (20000) @(posedge clk_i);
        fails++;
        print_verdict();
    end
endmodule : tb
`default_nettype wire
